// file: src/pmr_power_ctrl.sv
// What this block does
// - ready stays low until phy reset ends and phy reports operational
// - ready stays low while configuration loads from nonvolatile storage
// - bits 6:5 select sleep state zero to three, reset value 10b
// - on becoming unconfigured go unconfigured normal, selection back to 10b
// - sleep states zero and one behave the same
// - writing one to bit 4 resets the phy at least 4 ms
// - bit 4 clears itself when phy leaves reset, reset value 0
// - writes to bit 4 are ignored while it reads high
// - setting bit 4 drops ready at once, ready returns when phy operational
// - reset hold stretches to 128 ms unless analog settle wait skipped
// - bit 3 enables lan wake detections as wakeup events, reset 0
// - bit 2 enables phy interrupt as wakeup event, reset 0
// - both wake enables clear on resume completion when control set
// - clear control resets to 1, only remote wake resumes clear enables
// - after sleep state two, ready waits for phy to leave reset
`timescale 1ns/1ps
`default_nettype none
`include "pmr_regs.svh"

module pmr_power_ctrl
  import pmr_pkg::*;
#(
  parameter int CNT_W    = 25,
  parameter int HOLD_CYC = `PMR_HOLD_US * `PMR_CLK_MHZ,
  parameter int EXT_CYC  = `PMR_EXT_US * `PMR_CLK_MHZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        usb_configured,
  input  wire logic        host_suspend,
  input  wire logic        remote_wake,
  input  wire logic        cfg_load_busy,
  input  wire logic        phy_operational,
  output logic             phy_reset,
  output logic             device_ready,
  output logic             sleep_active,
  output logic [1:0]       sleep_state,
  output logic             lan_wake_enable,
  output logic             transceiver_irq_wake_enable
);

  localparam logic [CNT_W-1:0] HOLD_LD = CNT_W'(HOLD_CYC);
  localparam logic [CNT_W-1:0] EXT_LD  = CNT_W'(EXT_CYC);

  pmr_pwr_type       state_q;
  logic [1:0]        sel_q;
  logic              trig_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              hold_q;
  logic              skip_q;
  logic              rclr_q;
  logic              lan_q;
  logic              irq_q;
  logic              ready_q;
  logic [31:0]       prdata_q;
  logic [1:0]        busy_sync_q;
  logic [1:0]        op_sync_q;

  logic              acc;
  logic              wr_ctrl;
  logic              trig_set;
  logic              phy_hold;
  logic              hold_fall;
  logic              unconf_evt;
  logic              resume_done;
  logic              wake_clr;
  logic              ready_d;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `PMR_CTRL_ADDR) || (a == `PMR_STAT_ADDR);
  endfunction : mapped

  // zero-wait slave, read data captured during setup
  assign acc     = psel && penable;
  assign wr_ctrl = acc && pwrite && (paddr == `PMR_CTRL_ADDR);
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped(paddr);
  assign prdata  = prdata_q;

  // pin-side levels pass two flops first
  // busy resets high so ready cannot rise before the first real sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_sync_q <= 2'h3;
      op_sync_q   <= 2'h0;
    end else begin
      busy_sync_q <= {busy_sync_q[0], cfg_load_busy};
      op_sync_q   <= {op_sync_q[0], phy_operational};
    end
  end

  // a resume counts once, on the cycle the host lets go of suspend
  assign unconf_evt  = (state_q != PMR_UNCFG) && !usb_configured;
  assign resume_done = (state_q == PMR_SUSP) && !host_suspend && usb_configured;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PMR_UNCFG;
    end else begin
      case (state_q)
        PMR_UNCFG: if (usb_configured) begin
          state_q <= PMR_CFG;
        end
        PMR_CFG: if (!usb_configured) begin
          state_q <= PMR_UNCFG;
        end else if (host_suspend) begin
          state_q <= PMR_SUSP;
        end
        PMR_SUSP: if (!usb_configured) begin
          state_q <= PMR_UNCFG;
        end else if (!host_suspend) begin
          state_q <= PMR_CFG;
        end
        default: state_q <= PMR_UNCFG;
      endcase
    end
  end

  // hardware restore beats a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= `PMR_SEL_RST;
    end else if (unconf_evt) begin
      sel_q <= `PMR_SEL_RST;
    end else if (wr_ctrl) begin
      sel_q <= pwdata[`PMR_SEL_HI:`PMR_SEL_LO];
    end
  end

  // zero and one share one behaviour downstream
  assign sleep_state  = (sel_q == SLEEP_STATE_ONE) ? SLEEP_STATE_ZERO : sel_q;
  assign sleep_active = (state_q == PMR_SUSP);

  // phy kept in reset while unconfigured and during sleep state two
  assign phy_hold  = (state_q == PMR_UNCFG) ||
                     ((state_q == PMR_SUSP) && (sel_q == SLEEP_STATE_TWO));
  assign hold_fall = hold_q && !phy_hold;
  assign trig_set  = wr_ctrl && !trig_q && pwdata[`PMR_TRIG_BIT];

  // registered copy of the hold, its fall restarts the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b1;
    end else begin
      hold_q <= phy_hold;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (trig_set || hold_fall) begin
      // skip is taken as it stands before this write
      cnt_q <= skip_q ? HOLD_LD : EXT_LD;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= 1'b0;
    end else if (trig_set) begin
      trig_q <= 1'b1;
    // stays up until the phy really leaves reset, a restarted hold included
    end else if (trig_q && (cnt_q == CNT_W'(1)) && !phy_hold && !hold_fall) begin
      trig_q <= 1'b0;
    end
  end

  assign phy_reset = phy_hold || (cnt_q != '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_q <= `PMR_SKIP_RST;
      rclr_q <= `PMR_RCLR_RST;
    end else if (wr_ctrl) begin
      skip_q <= pwdata[`PMR_SKIP_BIT];
      rclr_q <= pwdata[`PMR_RCLR_BIT];
    end
  end

  // host-started resumes leave the enables alone
  assign wake_clr = resume_done && remote_wake && rclr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lan_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (wr_ctrl) begin
      lan_q <= pwdata[`PMR_LAN_BIT];
      irq_q <= pwdata[`PMR_IRQ_BIT];
    end else if (wake_clr) begin
      lan_q <= 1'b0;
      irq_q <= 1'b0;
    end
  end

  assign lan_wake_enable             = lan_q;
  assign transceiver_irq_wake_enable = irq_q;

  // trig_set folded in so ready drops on the same edge
  // ready from a flop, so bus decode glitches never reach the pin
  assign ready_d = !trig_set && !trig_q && !phy_hold && (cnt_q == '0) &&
                   op_sync_q[1] && !busy_sync_q[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
    end
  end

  assign device_ready = ready_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      // unmapped offsets read as zero
      prdata_q <= 32'h0000_0000;
      if (paddr == `PMR_CTRL_ADDR) begin
        prdata_q[`PMR_SKIP_BIT]              <= skip_q;
        prdata_q[`PMR_RCLR_BIT]              <= rclr_q;
        prdata_q[`PMR_READY_BIT]             <= ready_q;
        prdata_q[`PMR_SEL_HI:`PMR_SEL_LO]    <= sel_q;
        prdata_q[`PMR_TRIG_BIT]              <= trig_q;
        prdata_q[`PMR_LAN_BIT]               <= lan_q;
        prdata_q[`PMR_IRQ_BIT]               <= irq_q;
      end else if (paddr == `PMR_STAT_ADDR) begin
        prdata_q[`PMR_ST_HI:`PMR_ST_LO]      <= state_q;
        prdata_q[`PMR_ST_RST_BIT]            <= phy_reset;
        prdata_q[`PMR_ST_BUSY_BIT]           <= busy_sync_q[1];
        prdata_q[`PMR_ST_OP_BIT]             <= op_sync_q[1];
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ready is a flop, so checks on it look one edge later
  chk_ready_transceiver_reset_trigger: assert property (phy_reset |=> !device_ready)
    else $error("ready high while phy in reset");
  chk_ready_cfg_busy: assert property (busy_sync_q[1] |=> !device_ready)
    else $error("ready high while config loads");
  chk_ready_unconf: assert property (state_q == PMR_UNCFG |=> !device_ready)
    else $error("ready high while unconfigured");
  chk_ready_return: assert property (!phy_reset && !trig_q && !wr_ctrl &&
    op_sync_q[1] && !busy_sync_q[1] |=> device_ready)
    else $error("ready did not return after phy reset");
  chk_sel_write: assert property (wr_ctrl && !unconf_evt |=>
    sel_q == $past(pwdata[`PMR_SEL_HI:`PMR_SEL_LO]))
    else $error("sleep select write lost");
  chk_sel_restore: assert property (unconf_evt |=>
    (sel_q == `PMR_SEL_RST) && (state_q == PMR_UNCFG))
    else $error("unconfigured entry did not restore select");
  chk_sleep_merge: assert property (sleep_state != SLEEP_STATE_ONE)
    else $error("sleep state one not merged");
  chk_trig_load: assert property (trig_set |=>
    trig_q && !device_ready && cnt_q == ($past(skip_q) ? HOLD_LD : EXT_LD))
    else $error("reset hold not loaded");
  chk_trig_rise: assert property ($rose(trig_q) |->
    $past(wr_ctrl && pwdata[`PMR_TRIG_BIT]))
    else $error("reset bit set without a write");
  chk_trig_clear: assert property ($fell(trig_q) |->
    cnt_q == '0 && $past(cnt_q) == CNT_W'(1))
    else $error("reset bit cleared at wrong time");
  chk_trig_ignore: assert property (trig_q && cnt_q > CNT_W'(1) && !hold_fall |=>
    trig_q && cnt_q == $past(cnt_q) - CNT_W'(1))
    else $error("write disturbed running phy reset");
  chk_wake_write: assert property (wr_ctrl |=>
    lan_wake_enable == $past(pwdata[`PMR_LAN_BIT]) &&
    transceiver_irq_wake_enable == $past(pwdata[`PMR_IRQ_BIT]))
    else $error("wake enable write lost");
  chk_wake_clear: assert property (wake_clr && !wr_ctrl |=>
    !lan_wake_enable && !transceiver_irq_wake_enable)
    else $error("wake enables not cleared on resume");
  chk_host_resume: assert property (resume_done && !remote_wake && !wr_ctrl |=>
    $stable(lan_q) && $stable(irq_q))
    else $error("host resume changed wake enables");
  chk_susp2_hold: assert property (state_q == PMR_SUSP &&
    sel_q == SLEEP_STATE_TWO |-> phy_reset ##1 !device_ready)
    else $error("phy not held in sleep state two");

  // main scenarios, each seen at least once
  cov_trig_done: cover property (trig_set ##[1:1000] $fell(trig_q) ##[1:20] device_ready);
  cov_short_hold: cover property (trig_set && skip_q);
  cov_remote_resume: cover property (wake_clr && lan_q);
  cov_susp2_exit: cover property (hold_fall && state_q == PMR_CFG);
  cov_unconf: cover property (unconf_evt && sel_q != `PMR_SEL_RST);

endmodule : pmr_power_ctrl
`default_nettype wire

// file: src/pmr_regs.svh
`ifndef PMR_REGS_SVH
`define PMR_REGS_SVH
// byte addresses
`define PMR_CTRL_ADDR   8'h00
`define PMR_STAT_ADDR   8'h04
// control register fields
`define PMR_SKIP_BIT    15
`define PMR_RCLR_BIT    8
`define PMR_READY_BIT   7
`define PMR_SEL_HI      6
`define PMR_SEL_LO      5
`define PMR_TRIG_BIT    4
`define PMR_LAN_BIT     3
`define PMR_IRQ_BIT     2
// status register fields
`define PMR_ST_HI       1
`define PMR_ST_LO       0
`define PMR_ST_RST_BIT  2
`define PMR_ST_BUSY_BIT 3
`define PMR_ST_OP_BIT   4
// reset values
`define PMR_SEL_RST     2'h2
`define PMR_RCLR_RST    1'h1
`define PMR_SKIP_RST    1'h0
// timing
`define PMR_CLK_MHZ     200
`define PMR_HOLD_US     4000
`define PMR_EXT_US      128000
`endif

// file: src/pmr_pkg.sv
package pmr_pkg;
  typedef enum logic [1:0] {
    PMR_UNCFG = 2'h0,
    PMR_CFG   = 2'h1,
    PMR_SUSP  = 2'h3
  } pmr_pwr_type;

  typedef enum logic [1:0] {
    SLEEP_STATE_ZERO  = 2'h0,
    SLEEP_STATE_ONE   = 2'h1,
    SLEEP_STATE_TWO   = 2'h2,
    SLEEP_STATE_THREE = 2'h3
  } pmr_sleep_type;
endpackage : pmr_pkg

// file: test/pmr_phy_model.sv
`timescale 1ns/1ps
`default_nettype none

// phy comes up only some cycles after its reset is released
module pmr_phy_model #(
  parameter int OP_DLY = 8
) (
  input  wire logic clk,
  input  wire logic phy_reset,
  output logic      phy_operational
);
  int   cnt_q = 0;
  logic op_q  = 1'b0;

  always_ff @(posedge clk) begin
    if (phy_reset) begin
      cnt_q <= OP_DLY;
      op_q  <= 1'b0;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end else begin
      op_q <= 1'b1;
    end
  end

  assign phy_operational = op_q;
endmodule : pmr_phy_model
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
  import pmr_pkg::*;
  localparam int HOLD = 20;
  localparam int EXT  = 60;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr  = 0;
  logic [31:0] pwdata = 0, prdata, r, d;
  logic        pready, pslverr, cfgd = 0, susp = 0, rwake = 0, busy = 1;
  logic        phy_op, phy_held, rdy, sact, lan_en, irq_en;
  logic [1:0]  sst;
  logic [63:0] expq[$], e;
  logic [1:0]  sel_t[3] = '{2'h2, 2'h3, 2'h3};
  logic        rw_t[3]  = '{1'b1, 1'b0, 1'b1};
  logic        rc_t[3]  = '{1'b1, 1'b1, 1'b0};
  int          n_fail = 0, comparisons = 0, n;

  pmr_power_ctrl #(.HOLD_CYC(HOLD), .EXT_CYC(EXT)) pmr_power_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .usb_configured(cfgd),
    .host_suspend(susp), .remote_wake(rwake), .cfg_load_busy(busy),
    .phy_operational(phy_op), .phy_reset(phy_held), .device_ready(rdy),
    .sleep_active(sact), .sleep_state(sst), .lan_wake_enable(lan_en),
    .transceiver_irq_wake_enable(irq_en));

  pmr_phy_model pmr_phy_model_i (.clk(pclk), .phy_reset(phy_held), .phy_operational(phy_op));

  always #2.5 pclk = ~pclk;

  // result watcher: completed reads are checked against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      `CHK(pslverr, (paddr != 8'h00 && paddr != 8'h04))
      if (!pwrite && expq.size() > 0) begin
        e = expq.pop_front();
        `CHK(prdata & e[63:32], e[31:0])
      end
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= dd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    expq.push_back({m, x});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_rdy;
    n = 0;
    while (rdy !== 1'b1 && n < 500) begin
      @(negedge pclk);
      n++;
    end
    `CHK({rdy, phy_held, phy_op}, 3'b101)
  endtask : wait_rdy

  task print_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end

  initial begin
    r = $urandom(32'h48FE9C41);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'hFFFFFFFF, 32'h00000140);
    rd(8'h04, 32'hFFFFFFF7, 32'h00000004);
    rd(8'h0C, 32'hFFFFFFFF, 32'h00000000);
    apb(1'b1, 8'h00, 32'h00000140);
    cfgd <= 1'b1;
    repeat (100) @(negedge pclk);
    `CHK({rdy, phy_held, phy_op}, 3'b001)
    @(posedge pclk) busy <= 1'b0;
    wait_rdy();
    for (int s = 1; s >= 0; s--) begin
      d = {16'h0, s[0], 6'h0, 1'b1, 1'b0, 2'b10, 1'b1, 4'h0};
      // skip is read at trigger time, so it goes in one write ahead
      apb(1'b1, 8'h00, d ^ 32'h10);
      apb(1'b1, 8'h00, d);
      @(negedge pclk);
      `CHK(rdy, 1'b0)
      n = 0;
      fork
        while (phy_held === 1'b1 && n < 200) begin
          @(negedge pclk);
          n++;
        end
        begin
          apb(1'b1, 8'h00, d);
          rd(8'h00, 32'h00000010, 32'h00000010);
        end
      join
      `CHK(n, s ? HOLD : EXT)
      rd(8'h00, 32'h00000010, 32'h0);
      wait_rdy();
    end
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      d = {23'h0, 1'b1, 1'b0, i[1:0], 1'b0, r[1:0], 2'b0};
      apb(1'b1, 8'h00, d);
      rd(8'h00, 32'h0000017C, d);
      @(negedge pclk);
      `CHK(sst, (i == 1) ? 2'h0 : i[1:0])
      `CHK({lan_en, irq_en}, r[1:0])
    end
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 8'h00, {23'h0, rc_t[k], 1'b0, sel_t[k], 1'b0, 2'b11, 2'b0});
      rwake <= rw_t[k];
      susp  <= 1'b1;
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      `CHK(sact, 1'b1)
      if (k == 0) `CHK(phy_held, 1'b1)
      @(posedge pclk) susp <= 1'b0;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      `CHK({lan_en, irq_en}, (rw_t[k] & rc_t[k]) ? 2'b00 : 2'b11)
      if (k == 0) begin
        apb(1'b1, 8'h00, 32'h00000150);
        wait_rdy();
      end
    end
    apb(1'b1, 8'h00, 32'h00000160);
    @(posedge pclk) cfgd <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(8'h00, 32'h00000060, 32'h00000040);
    @(negedge pclk);
    `CHK({phy_held, rdy}, 2'b10)
    repeat (3) @(posedge pclk);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
